//--- rtl/spi_cycle_counter.sv
// Machine cycle position counter, one count per shaft degree.
// Assumes deg_step is a one-cycle pulse synchronous to clk.
`timescale 1ns/1ps
module spi_cycle_counter
   import spi_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic deg_step,
   output logic [8:0] deg_q,
   output logic wrap_q
);

   logic [8:0] deg_d;
   logic wrap_d;

   // Advance the position and flag the wrap into a new cycle.
   always_comb begin
      deg_d = deg_q;
      wrap_d = 1'b0;
      if (deg_step) begin
         if (deg_q == SPI_DEG_LAST) begin
            deg_d = SPI_DEG_RESET;
            wrap_d = 1'b1;
         end else begin
            deg_d = deg_q + 9'h001;
         end
      end
   end

   // Register the position.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         deg_q <= SPI_DEG_RESET;
         wrap_q <= 1'b0;
      end else begin
         deg_q <= deg_d;
         wrap_q <= wrap_d;
      end
   end

endmodule : spi_cycle_counter

//--- rtl/spi_digit_select.sv
// Digit and credit X selection onto the punch magnets.
// Assumes index_strobe marks one punch emitter impulse at punch_index.
`timescale 1ns/1ps
module spi_digit_select
   import spi_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic index_strobe,
   input wire logic [3:0] punch_index,
   input wire logic path_open,
   input wire logic [31:0] digits,
   input wire logic x_enable,
   input wire logic [2:0] x_column,
   output logic [SPI_COLUMNS-1:0] magnet_q
);

   logic [SPI_COLUMNS-1:0] magnet_d;

   // Route each impulse to every column whose counter holds that digit.
   always_comb begin
      magnet_d = '0;
      if (index_strobe && path_open) begin
         for (int c = 0; c < SPI_COLUMNS; c++) begin
            if (punch_index <= SPI_INDEX_DIGIT_MAX && digits[c*4 +: 4] == punch_index) begin
               magnet_d[c] = 1'b1;
            end
         end
         if (punch_index == SPI_INDEX_X && x_enable) begin
            magnet_d[x_column] = 1'b1;
         end
      end
   end

   // Magnets are one-cycle pulses per impulse.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         magnet_q <= '0;
      end else begin
         magnet_q <= magnet_d;
      end
   end

endmodule : spi_digit_select

//--- rtl/spi_interlock.sv
// Summary punch interlock of the accounting machine: program suspend, punch start, end release.
// Assumes the punch keeps its own first-cycle, cycle-active and emitter gating relays.
//
// Notes on behaviour
// - Start impulse leaves only while the start window breaker is closed from 267 degrees.
// - Sign test is sampled from 255 up to 267 degrees, before the start window.
// - A demanded correction cycle holds the start back until that cycle ends.
// - Each wired column gets the emitter impulse matching its counter digit, 0 to 9.
// - One start pick per control change; emitter active one cycle per card.
// - End cam sets the punch end relay, which then holds by the end hold breaker.
// - Punch end releases the suspend relay and its parallel group.
// - Punch end blocks program pick re-setting and punch start re-picking.
// - Card feed stop lamp lit while punching pends, dark when the path relay drops.
// - Release re-enables print clutch, drops idle cycles, restores all cycles.
// - Idle cycles hold lasts until 280 degrees, past the early all-cycle window.
// - No program test impulse from 246 to 271 degrees after the punch cycle.
// - Sign selection relays hold through punching up to 202 degrees.
// - Credit X goes to the chosen column at index 11 with sign and path relays set.
// - One sign control relay per group, set only when converted; plus option inverts.
// - Minor program sets suspend from program pick, holding off total cycle.
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module spi_interlock
   import spi_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [31:0] reg_rdata_q,
   input wire logic deg_step,
   input wire logic minor_program,
   input wire logic [SPI_GROUPS-1:0] group_negative,
   input wire logic punch_request,
   input wire logic end_cam,
   input wire logic index_strobe,
   input wire logic [3:0] punch_index,
   output logic punch_start_q,
   output logic [SPI_COLUMNS-1:0] punch_magnet_q,
   output logic program_pick_relay_q,
   output logic suspend_relay_q,
   output logic punch_path_relay_q,
   output logic punch_end_relay_q,
   output logic print_clutch_control_q,
   output logic idle_cycles_relay_q,
   output logic all_cycles_relay_q,
   output logic program_test_q,
   output logic card_feed_stop_lamp_q
);

   ////////////////////////////////////////////////////////////////////////////////
   // Position counter and decoded cam windows.

   logic [8:0] deg;
   logic wrap;

   spi_cycle_counter u_counter (
      .clk(clk),
      .sys_rst(sys_rst),
      .deg_step(deg_step),
      .deg_q(deg),
      .wrap_q(wrap)
   );

   logic sign_test_breaker;
   logic start_window_breaker;
   logic idle_hold_breaker;
   logic end_hold_breaker;
   logic early_all_window;
   logic sign_hold_window;

   // Breakers as windows on the cycle position.
   assign sign_test_breaker = spi_in_window(deg, SPI_SIGN_TEST_OPEN_DEG, SPI_START_WINDOW_DEG);
   assign start_window_breaker = spi_in_window(deg, SPI_START_WINDOW_DEG, SPI_START_WINDOW_END_DEG);
   assign idle_hold_breaker = deg < SPI_IDLE_HOLD_OPEN_DEG;
   assign end_hold_breaker = deg != SPI_END_HOLD_OPEN_DEG;
   assign early_all_window = spi_in_window(deg, SPI_EARLY_ALL_OPEN_DEG, SPI_EARLY_ALL_CLOSE_DEG);
   assign sign_hold_window = deg < SPI_SIGN_HOLD_END_DEG;

   ////////////////////////////////////////////////////////////////////////////////
   // Software registers.

   logic [31:0] ctrl_q;
   logic [31:0] ctrl_d;
   logic [31:0] digits_q;
   logic [31:0] digits_d;
   logic [31:0] reg_rdata_d;
   logic [31:0] status_word;
   logic enable;
   logic plus_select;
   logic [SPI_GROUPS-1:0] convert_mask;
   logic [2:0] x_column;
   logic [1:0] x_group;

   assign enable = ctrl_q[SPI_CTRL_ENABLE_BIT];
   assign plus_select = ctrl_q[SPI_CTRL_PLUS_BIT];
   assign convert_mask = ctrl_q[SPI_CTRL_CONVERT_LSB +: SPI_GROUPS];
   assign x_column = ctrl_q[SPI_CTRL_XCOL_LSB +: 3];
   assign x_group = ctrl_q[SPI_CTRL_XGRP_LSB +: 2];

   // Write decode and one-cycle-late read data.
   always_comb begin
      ctrl_d = ctrl_q;
      digits_d = digits_q;
      reg_rdata_d = 32'h0000_0000;
      if (reg_write) begin
         case (reg_addr)
            SPI_REG_CTRL: ctrl_d = reg_wdata & 32'h0000_07FF;
            SPI_REG_DIGITS: digits_d = reg_wdata;
            default: ctrl_d = ctrl_q;
         endcase
      end
      if (reg_read) begin
         case (reg_addr)
            SPI_REG_CTRL: reg_rdata_d = ctrl_q;
            SPI_REG_DIGITS: reg_rdata_d = digits_q;
            SPI_REG_STATUS: reg_rdata_d = status_word;
            SPI_REG_POSITION: reg_rdata_d = {23'h000000, deg};
            default: reg_rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_q <= SPI_CTRL_RESET;
         digits_q <= SPI_DIGITS_RESET;
         reg_rdata_q <= 32'h0000_0000;
      end else begin
         ctrl_q <= ctrl_d;
         digits_q <= digits_d;
         reg_rdata_q <= reg_rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Sign test, correction cycle and group sign control relays.

   spi_corr_type corr_q;
   spi_corr_type corr_d;
   logic [SPI_GROUPS-1:0] group_sign_q;
   logic [SPI_GROUPS-1:0] group_sign_d;
   logic corr_block;

   assign corr_block = corr_q != SPI_CORR_IDLE;

   // A negative converted group blocks the start until its correction cycle ends.
   always_comb begin
      corr_d = corr_q;
      group_sign_d = group_sign_q;
      if (!(idle_cycles_relay_q || punch_path_relay_q || sign_hold_window)) begin
         group_sign_d = '0;
      end
      if (sign_test_breaker && deg_step) begin
         group_sign_d = group_sign_d | (group_negative & convert_mask);
         if ((group_negative & convert_mask) != '0) begin
            corr_d = SPI_CORR_WAIT;
         end
      end
      case (corr_q)
         SPI_CORR_IDLE: ;
         SPI_CORR_WAIT: if (wrap) corr_d = SPI_CORR_RUN;
         SPI_CORR_RUN: if (wrap) corr_d = SPI_CORR_IDLE;
         default: corr_d = SPI_CORR_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         corr_q <= SPI_CORR_IDLE;
         group_sign_q <= '0;
      end else begin
         corr_q <= corr_d;
         group_sign_q <= group_sign_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Program suspend, punch start and punch end relays.

   logic program_pick_d;
   logic suspend_d;
   logic punch_end_d;
   logic start_taken_q;
   logic start_taken_d;
   logic punch_start_d;
   logic lamp_d;

   // Suspend sequence from program pick to punch end release.
   always_comb begin
      program_pick_d = program_pick_relay_q;
      suspend_d = suspend_relay_q;
      punch_end_d = punch_end_relay_q;
      start_taken_d = start_taken_q;
      punch_start_d = 1'b0;
      if (wrap) begin
         program_pick_d = 1'b0;
      end
      if (minor_program && enable && !punch_end_relay_q) begin
         program_pick_d = 1'b1;
      end
      if (program_pick_relay_q) begin
         suspend_d = 1'b1;
      end
      if (punch_end_relay_q) begin
         suspend_d = 1'b0;
         start_taken_d = 1'b0;
      end
      if (!end_hold_breaker && !end_cam) begin
         punch_end_d = 1'b0;
      end
      if (end_cam && suspend_relay_q) begin
         punch_end_d = 1'b1;
      end
      if (suspend_relay_q && punch_request && start_window_breaker && !corr_block
          && !start_taken_q && !punch_end_relay_q) begin
         punch_start_d = 1'b1;
         start_taken_d = 1'b1;
      end
      lamp_d = suspend_d;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         program_pick_relay_q <= 1'b0;
         suspend_relay_q <= 1'b0;
         punch_path_relay_q <= 1'b0;
         punch_end_relay_q <= 1'b0;
         start_taken_q <= 1'b0;
         punch_start_q <= 1'b0;
         card_feed_stop_lamp_q <= 1'b0;
      end else begin
         program_pick_relay_q <= program_pick_d;
         suspend_relay_q <= suspend_d;
         punch_path_relay_q <= suspend_d;
         punch_end_relay_q <= punch_end_d;
         start_taken_q <= start_taken_d;
         punch_start_q <= punch_start_d;
         card_feed_stop_lamp_q <= lamp_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Print clutch, idle cycles and all cycles relays.

   logic print_clutch_d;
   logic idle_cycles_d;
   logic all_cycles_d;
   logic program_test_d;

   // The idle hold outlasts the early all-cycle window before all cycles returns.
   always_comb begin
      print_clutch_d = !suspend_relay_q;
      idle_cycles_d = idle_cycles_relay_q;
      if (!print_clutch_control_q) begin
         idle_cycles_d = 1'b1;
      end else if (!idle_hold_breaker) begin
         idle_cycles_d = 1'b0;
      end
      all_cycles_d = !idle_cycles_relay_q;
      program_test_d = all_cycles_relay_q && early_all_window;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         print_clutch_control_q <= 1'b1;
         idle_cycles_relay_q <= 1'b0;
         all_cycles_relay_q <= 1'b1;
         program_test_q <= 1'b0;
      end else begin
         print_clutch_control_q <= print_clutch_d;
         idle_cycles_relay_q <= idle_cycles_d;
         all_cycles_relay_q <= all_cycles_d;
         program_test_q <= program_test_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Digit and credit X routing to the punch magnets.

   logic x_enable;

   // Plus wiring marks positive totals instead of converted ones.
   assign x_enable = punch_path_relay_q && (plus_select ? !group_sign_q[x_group] : group_sign_q[x_group]);

   spi_digit_select u_select (
      .clk(clk),
      .sys_rst(sys_rst),
      .index_strobe(index_strobe),
      .punch_index(punch_index),
      .path_open(punch_path_relay_q && start_taken_q),
      .digits(digits_q),
      .x_enable(x_enable),
      .x_column(x_column),
      .magnet_q(punch_magnet_q)
   );

   // Status word for software.
   assign status_word = {16'h0000, group_sign_q, 1'b0, corr_block, start_taken_q, card_feed_stop_lamp_q,
                         all_cycles_relay_q, idle_cycles_relay_q, print_clutch_control_q, punch_end_relay_q,
                         punch_path_relay_q, suspend_relay_q, program_pick_relay_q, punch_start_q};

endmodule : spi_interlock

//--- rtl/spi_pkg.sv
// Package for the summary punch interlock: cam windows, register map and reset values.
// Assumes one 40 MHz clock and a machine shaft that advances one degree per deg_step pulse.
package spi_pkg;

   // Clock rate and the cycle position counter.
   localparam int unsigned SPI_CLK_HZ = 40000000;
   localparam int unsigned SPI_DEG_PER_CYCLE = 360;
   localparam logic [8:0] SPI_DEG_LAST = 9'h167;
   localparam logic [8:0] SPI_DEG_RESET = 9'h000;

   // Cam and breaker windows in degrees of the machine cycle.
   localparam logic [8:0] SPI_SIGN_TEST_OPEN_DEG = 9'h0FF;
   localparam logic [8:0] SPI_START_WINDOW_DEG = 9'h10B;
   localparam logic [8:0] SPI_START_WINDOW_END_DEG = 9'h140;
   localparam logic [8:0] SPI_IDLE_HOLD_OPEN_DEG = 9'h118;
   localparam logic [8:0] SPI_END_HOLD_OPEN_DEG = 9'h0C8;
   localparam logic [8:0] SPI_SIGN_HOLD_END_DEG = 9'h0CA;
   localparam logic [8:0] SPI_EARLY_ALL_OPEN_DEG = 9'h0F6;
   localparam logic [8:0] SPI_EARLY_ALL_CLOSE_DEG = 9'h10F;

   // Punch index positions.
   localparam logic [3:0] SPI_INDEX_DIGIT_MAX = 4'h9;
   localparam logic [3:0] SPI_INDEX_X = 4'hB;

   // Geometry of the wired columns and counter groups.
   localparam int unsigned SPI_COLUMNS = 8;
   localparam int unsigned SPI_GROUPS = 4;

   // Register offsets.
   localparam logic [3:0] SPI_REG_CTRL = 4'h0;
   localparam logic [3:0] SPI_REG_DIGITS = 4'h4;
   localparam logic [3:0] SPI_REG_STATUS = 4'h8;
   localparam logic [3:0] SPI_REG_POSITION = 4'hC;

   // Control field positions.
   localparam int unsigned SPI_CTRL_ENABLE_BIT = 0;
   localparam int unsigned SPI_CTRL_PLUS_BIT = 1;
   localparam int unsigned SPI_CTRL_CONVERT_LSB = 2;
   localparam int unsigned SPI_CTRL_XCOL_LSB = 6;
   localparam int unsigned SPI_CTRL_XGRP_LSB = 9;

   // Values after reset.
   localparam logic [31:0] SPI_CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] SPI_DIGITS_RESET = 32'h0000_0000;

   // Correction cycle tracking.
   typedef enum logic [1:0] {
      SPI_CORR_IDLE,
      SPI_CORR_WAIT,
      SPI_CORR_RUN
   } spi_corr_type;

   // True when a degree lies in a half-open window.
   function automatic logic spi_in_window(input logic [8:0] deg, input logic [8:0] lo, input logic [8:0] hi);
      spi_in_window = (deg >= lo) && (deg < hi);
   endfunction : spi_in_window

endpackage : spi_pkg

//--- test/spi_interlock_properties.sv
// Checker of the interlock timing at the ports of spi_interlock.
// Assumes deg_step advances the shaft one degree, as in the design.
`timescale 1ns/1ps
module spi_interlock_properties
   import spi_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic deg_step,
   input wire logic punch_request,
   input wire logic index_strobe,
   input wire logic punch_start_q,
   input wire logic [SPI_COLUMNS-1:0] punch_magnet_q,
   input wire logic program_pick_relay_q,
   input wire logic suspend_relay_q,
   input wire logic punch_path_relay_q,
   input wire logic punch_end_relay_q,
   input wire logic print_clutch_control_q,
   input wire logic idle_cycles_relay_q,
   input wire logic all_cycles_relay_q,
   input wire logic program_test_q,
   input wire logic card_feed_stop_lamp_q
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   logic [8:0] deg_q;
   logic [8:0] deg_d;
   logic started_q;
   logic started_d;
   ////////////////////////////////
   // Shadow shaft position and the start already given in this suspend spell.
   always_comb begin
      deg_d = deg_q;
      if (deg_step) begin
         deg_d = (deg_q == SPI_DEG_LAST) ? SPI_DEG_RESET : deg_q + 9'h001;
      end
      started_d = suspend_relay_q && (started_q || punch_start_q);
   end
   // Registers of the shadow state.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         deg_q <= SPI_DEG_RESET;
         started_q <= 1'b0;
      end else begin
         deg_q <= deg_d;
         started_q <= started_d;
      end
   end
   ////////////////////////////////
   a_start_window: assert property (punch_start_q |-> $past(deg_q) >= SPI_START_WINDOW_DEG
      && $past(deg_q) < SPI_START_WINDOW_END_DEG && $past(suspend_relay_q) && $past(punch_request))
      else $error("start outside its window");
   a_start_once: assert property (punch_start_q |-> !started_q) else $error("second start");
   a_pick_suspend: assert property ($rose(program_pick_relay_q) |=> suspend_relay_q)
      else $error("suspend not set");
   a_path_lamp: assert property ($rose(suspend_relay_q) |=> punch_path_relay_q && card_feed_stop_lamp_q)
      else $error("path or lamp late");
   a_lamp_dark: assert property ($fell(punch_path_relay_q) |-> !card_feed_stop_lamp_q)
      else $error("lamp lit after path");
   a_end_release: assert property ($rose(punch_end_relay_q) |=> !suspend_relay_q ##1 !punch_path_relay_q)
      else $error("suspend not released");
   a_end_no_pick: assert property (punch_end_relay_q && !program_pick_relay_q |=> !program_pick_relay_q)
      else $error("pick during end");
   a_end_no_start: assert property (punch_end_relay_q |=> !punch_start_q)
      else $error("start during end");
   a_idle_follow: assert property ($fell(print_clutch_control_q) |=> idle_cycles_relay_q ##1
      !all_cycles_relay_q) else $error("idle chain late");
   a_idle_hold: assert property ($fell(idle_cycles_relay_q) |-> $past(deg_q) >= SPI_IDLE_HOLD_OPEN_DEG
      && $past(print_clutch_control_q)) else $error("idle dropped early");
   a_test_window: assert property (program_test_q |-> $past(all_cycles_relay_q)
      && $past(deg_q) >= SPI_EARLY_ALL_OPEN_DEG && $past(deg_q) < SPI_EARLY_ALL_CLOSE_DEG)
      else $error("test impulse off window");
   a_magnet_cause: assert property (punch_magnet_q != '0 |-> $past(index_strobe)
      && $past(punch_path_relay_q)) else $error("magnet without impulse");
endmodule : spi_interlock_properties
bind spi_interlock spi_interlock_properties chk (.clk(clk), .sys_rst(sys_rst), .deg_step(deg_step),
   .punch_request(punch_request), .index_strobe(index_strobe), .punch_start_q(punch_start_q),
   .punch_magnet_q(punch_magnet_q), .program_pick_relay_q(program_pick_relay_q), .suspend_relay_q(suspend_relay_q),
   .punch_path_relay_q(punch_path_relay_q), .punch_end_relay_q(punch_end_relay_q),
   .print_clutch_control_q(print_clutch_control_q), .idle_cycles_relay_q(idle_cycles_relay_q),
   .all_cycles_relay_q(all_cycles_relay_q), .program_test_q(program_test_q),
   .card_feed_stop_lamp_q(card_feed_stop_lamp_q));

//--- test/spi_punch_model.sv
// Behavioural model of the attached summary punch with its cams.
// Assumes one-cycle start pulses; the bench arms a request per episode.
`timescale 1ns/1ps
module spi_punch_model (
   input wire logic clk,
   input wire logic arm,
   input wire logic [3:0] gap,
   input wire logic punch_start,
   output logic punch_request,
   output logic end_cam,
   output logic index_strobe,
   output logic [3:0] punch_index
);
   logic cycle_active;
   logic first_cycle;
   logic feed_pick;
   logic done;
   int k;
   ////////////////////////////////
   // One pass is one idle clock or a whole punch cycle, so starts in a cycle are ignored.
   initial begin
      punch_request = 1'b0;
      end_cam = 1'b0;
      index_strobe = 1'b0;
      punch_index = 4'hF;
      cycle_active = 1'b0;
      first_cycle = 1'b0;
      feed_pick = 1'b0;
      done = 1'b0;
      forever begin
         @(posedge clk);
         if (!arm) begin
            done = 1'b0;
         end
         punch_request <= arm && !done;
         if (punch_start && punch_request && !cycle_active) begin
            feed_pick = 1'b1;
            cycle_active = 1'b1;
            first_cycle = 1'b1;
            for (k = 0; k < 11; k++) begin
               repeat (gap) @(posedge clk);
               @(posedge clk);
               index_strobe <= 1'b1;
               punch_index <= (k == 0) ? 4'hB : 4'(k - 1);
               @(posedge clk);
               index_strobe <= 1'b0;
               punch_index <= ~punch_index;
            end
            end_cam <= 1'b1;
            repeat (3) @(posedge clk);
            end_cam <= 1'b0;
            punch_request <= 1'b0;
            done = 1'b1;
            @(posedge clk);
            cycle_active = 1'b0;
            feed_pick = 1'b0;
         end
      end
   end
endmodule : spi_punch_model

//--- test/summary_punch_interlock_tb.sv
// Self-checking bench of the summary punch interlock.
// Assumes the punch model and the bound checker beside the design.
`timescale 1ns/1ps
module summary_punch_interlock_tb
   import spi_pkg::*;
;
   logic clk;
   logic sys_rst;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata;
   logic reg_write;
   logic reg_read;
   logic [31:0] reg_rdata_q;
   logic deg_step;
   logic minor_program;
   logic [SPI_GROUPS-1:0] group_negative;
   logic punch_request;
   logic end_cam;
   logic index_strobe;
   logic [3:0] punch_index;
   logic punch_start_q;
   logic [SPI_COLUMNS-1:0] punch_magnet_q;
   logic [8:0] rel;
   logic arm;
   logic [3:0] gap;
   logic strb_s;
   logic [3:0] idx_s;
   logic [SPI_COLUMNS-1:0] log_m [0:15];
   int miscompares;
   int num_checks;
   int starts;
   int cycles;
   int tdeg;
   spi_interlock uut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata_q(reg_rdata_q), .deg_step(deg_step),
      .minor_program(minor_program), .group_negative(group_negative), .punch_request(punch_request),
      .end_cam(end_cam), .index_strobe(index_strobe), .punch_index(punch_index), .punch_start_q(punch_start_q),
      .punch_magnet_q(punch_magnet_q), .program_pick_relay_q(rel[0]), .suspend_relay_q(rel[1]),
      .punch_path_relay_q(rel[2]), .punch_end_relay_q(rel[3]), .print_clutch_control_q(rel[4]),
      .idle_cycles_relay_q(rel[5]), .all_cycles_relay_q(rel[6]), .program_test_q(rel[7]),
      .card_feed_stop_lamp_q(rel[8]));
   spi_punch_model far (.clk(clk), .arm(arm), .gap(gap), .punch_start(punch_start_q),
      .punch_request(punch_request), .end_cam(end_cam), .index_strobe(index_strobe), .punch_index(punch_index));
   ////////////////////////////////
   // Prints the verdict and stops the run.
   task automatic end_of_test();
      if (miscompares == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_of_test
   // Compares one value and reports a difference.
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   // Register write of one cycle.
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask : wr
   // Register read; data stand only in the cycle after the strobe.
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      @(negedge clk);
      d = reg_rdata_q;
   endtask : rd
   // Advances the shaft by n degrees.
   task automatic step(input int n);
      repeat (n) begin
         @(posedge clk);
         deg_step <= 1'b1;
         @(posedge clk);
         deg_step <= 1'b0;
         tdeg = (tdeg == 359) ? 0 : tdeg + 1;
      end
   endtask : step
   // Runs one summary punch episode, with or without a credit correction.
   task automatic episode(input logic plus, input logic credit);
      logic [31:0] dig;
      logic [31:0] ctl;
      logic [31:0] v;
      logic [SPI_COLUMNS-1:0] e;
      int c;
      int k;
      for (c = 0; c < SPI_COLUMNS; c++) begin
         dig[4*c +: 4] = 4'($urandom % 10);
      end
      dig[3:0] = 4'h0;
      dig[31:28] = 4'h9;
      ctl = {21'h0, 2'($urandom), 3'($urandom), 4'hF, plus, 1'b1};
      for (k = 0; k < 16; k++) begin
         log_m[k] = '0;
      end
      wr(SPI_REG_CTRL, ctl);
      wr(SPI_REG_DIGITS, dig);
      rd(SPI_REG_CTRL, v);
      check(v, ctl);
      starts = 0;
      @(posedge clk);
      group_negative <= credit ? 4'(4'h1 << ctl[10:9]) : 4'h0;
      arm <= 1'b1;
      gap <= 4'($urandom % 4);
      minor_program <= 1'b1;
      @(posedge clk);
      minor_program <= 1'b0;
      repeat (6) @(posedge clk);
      rd(SPI_REG_STATUS, v);
      check(v & 32'h0000_01FF, 32'h0000_014E);
      while (tdeg != 300) step(1);
      check(32'(starts), credit ? 32'h0 : 32'h1);
      group_negative <= 4'h0;
      for (k = 0; starts == 0 && k < 1200; k++) step(1);
      for (k = 0; punch_request !== 1'b0 && k < 400; k++) @(posedge clk);
      arm <= 1'b0;
      step(400);
      rd(SPI_REG_STATUS, v);
      check(v & 32'h0000_01FF, 32'h0000_00A0);
      check(32'(rel & 9'h17F), 32'h0000_0050);
      check(32'(starts), 32'h1);
      for (c = 0; c < 10; c++) begin
         for (k = 0; k < SPI_COLUMNS; k++) e[k] = (dig[4*k +: 4] == 4'(c));
         check(32'(log_m[c]), 32'(e));
      end
      check(32'(log_m[11]), (plus ^ credit) ? 32'h1 << ctl[8:6] : 32'h0);
   endtask : episode
   ////////////////////////////////
   // Clock of 25 ns.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Logs magnets against the impulse seen one cycle earlier and counts starts.
   always @(negedge clk) begin
      if (strb_s === 1'b1) log_m[idx_s] = log_m[idx_s] | punch_magnet_q;
      strb_s = index_strobe;
      idx_s = punch_index;
      if (punch_start_q === 1'b1) starts++;
   end
   // Cuts a hang short.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         end_of_test();
      end
   end
   // Main sequence: reset values, access kinds, then three episodes.
   initial begin
      logic [31:0] v;
      static logic [3:0] adr [5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
      static logic [31:0] rv [5] = '{SPI_CTRL_RESET, SPI_DIGITS_RESET, 32'h0000_00A0, 32'h0000_0000, 32'h0000_0000};
      int i;
      sys_rst = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 32'h0000_0000;
      reg_write = 1'b0;
      reg_read = 1'b0;
      deg_step = 1'b0;
      minor_program = 1'b0;
      group_negative = 4'h0;
      arm = 1'b0;
      gap = 4'h0;
      tdeg = 0;
      v = $urandom(32'h4DF91D30);
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      for (i = 0; i < 5; i++) begin
         rd(adr[i], v);
         check(v, rv[i]);
      end
      wr(SPI_REG_STATUS, 32'hFFFF_FFFF);
      wr(SPI_REG_CTRL, 32'hFFFF_FFFF);
      rd(SPI_REG_STATUS, v);
      check(v, 32'h0000_00A0);
      rd(SPI_REG_CTRL, v);
      check(v, 32'h0000_07FF);
      step(10);
      rd(SPI_REG_POSITION, v);
      check(v, 32'(tdeg));
      episode(1'b1, 1'b0);
      episode(1'b0, 1'b0);
      episode(1'b0, 1'b1);
      // Test impulse stands inside the early all-cycle window once all cycles is back, and not after it.
      while (tdeg != 250) step(1);
      repeat (2) @(negedge clk);
      check(32'(rel[7]), 32'h1);
      step(21);
      repeat (2) @(negedge clk);
      check(32'(rel[7]), 32'h0);
      end_of_test();
   end
endmodule : summary_punch_interlock_tb
